// [logic/fwlt_pkg.sv]
// Purpose: Constants and types for the feedwater-loss trip channel.
// Assumes: Flux in hundredths of a percent of rated power; APB byte addresses.
// Notes: Rules carried out by the channel and its bench, tagged in the code.
// Behaviour
// - Enable the trip once selected power reaches the enable setpoint, default 1.75.
// - Bypass the trip once selected power falls to the bypass setpoint, default 0.5.
// - Enable state holds between the two setpoints, giving hysteresis.
// - Bypass setpoint only resets the enable comparator, never trips on its own.
// - Legacy mode trips on own A and B contacts open and own flux enabled.
// - An open contact means the turbine is tripped; closed means not tripped.
// - Flux is percent of rated power, expected span zero to 125.
// - Proposed mode uses the second highest of four flux values.
// - Proposed mode trips on two of four A open, two of four B open, enabled.
// - Proposed mode bypasses when second highest flux is at or below bypass setpoint.
// - Setpoints and algorithm selection live in software-writable registers.
// - Calculated values are neither clamped nor flagged against expected spans.
// - All eight contact states are shared so each channel can vote.
// - Manual shutdown bypass does not inhibit this trip.
// - Alert asserts on two of four open on A or B, ignoring bypass.
package fwlt_pkg;
  localparam int FLUX_W = 16;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_SP = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_BYPASS_SP = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_MAX = 12'h010;
  localparam int CTRL_MODE_BIT = 0;
  localparam int ST_TRIP_BIT = 0;
  localparam int ST_ENABLED_BIT = 1;
  localparam int ST_ALERT_BIT = 2;
  localparam int ST_BYPASS_BIT = 3;
  localparam int ST_SHUTDOWN_BIT = 4;
  localparam logic [FLUX_W-1:0] ENABLE_SP_RST = 16'h00af;
  localparam logic [FLUX_W-1:0] BYPASS_SP_RST = 16'h0032;
  localparam logic [FLUX_W-1:0] FLUX_FULL_SCALE = 16'h30d4;
  localparam logic [2:0] VOTE_MIN = 3'h2;

  typedef enum logic {
    FWLT_LEGACY = 1'b0,
    FWLT_PROPOSED = 1'b1
  } fwlt_mode_type;

  typedef enum logic {
    FWLT_CMP_BYPASSED = 1'b0,
    FWLT_CMP_ENABLED = 1'b1
  } fwlt_cmp_type;

  typedef struct packed {
    logic [NUM_CH-1:0][FLUX_W-1:0] ch;
  } fwlt_flux_type;

  typedef struct packed {
    logic [NUM_CH-1:0] pump_a_pressure_contact;
    logic [NUM_CH-1:0] pump_b_pressure_contact;
  } fwlt_contacts_type;

  typedef struct packed {
    logic channel_trip;
    logic pressure_alert;
    logic trip_bypassed;
    logic power_enabled;
  } fwlt_out_type;
endpackage

// [logic/fwlt_trip_channel.sv]
// Purpose: One protection channel's loss-of-both-feedwater-pumps trip decision.
// Assumes: Contact input high means contact closed; all inputs synchronous to pclk.
// Notes: Registers over APB, zero wait states while ce is high.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fwlt_trip_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fwlt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] channel_index,
  input wire logic shutdown_bypass,
  input wire fwlt_pkg::fwlt_flux_type flux_in,
  input wire fwlt_pkg::fwlt_contacts_type contacts_in,
  output fwlt_pkg::fwlt_out_type trip_out
);

  function automatic logic [fwlt_pkg::FLUX_W-1:0] max2(
    input logic [fwlt_pkg::FLUX_W-1:0] a,
    input logic [fwlt_pkg::FLUX_W-1:0] b
  );
    max2 = (a >= b) ? a : b;
  endfunction

  function automatic logic [fwlt_pkg::FLUX_W-1:0] min2(
    input logic [fwlt_pkg::FLUX_W-1:0] a,
    input logic [fwlt_pkg::FLUX_W-1:0] b
  );
    min2 = (a >= b) ? b : a;
  endfunction

  // Second highest of four; a tie at the top returns the tied value
  function automatic logic [fwlt_pkg::FLUX_W-1:0] second_max(
    input fwlt_pkg::fwlt_flux_type f
  );
    logic [fwlt_pkg::FLUX_W-1:0] hi1;
    logic [fwlt_pkg::FLUX_W-1:0] lo1;
    logic [fwlt_pkg::FLUX_W-1:0] hi2;
    logic [fwlt_pkg::FLUX_W-1:0] lo2;
    hi1 = max2(f.ch[0], f.ch[1]);
    lo1 = min2(f.ch[0], f.ch[1]);
    hi2 = max2(f.ch[2], f.ch[3]);
    lo2 = min2(f.ch[2], f.ch[3]);
    second_max = max2(min2(hi1, hi2), max2(lo1, lo2));
  endfunction

  // Open contacts are tripped turbines; true when two or more are open
  function automatic logic vote_two_of_four(
    input logic [fwlt_pkg::NUM_CH-1:0] closed
  );
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < fwlt_pkg::NUM_CH; i++) begin
      n = n + {2'h0, ~closed[i]};
    end
    vote_two_of_four = (n >= fwlt_pkg::VOTE_MIN);
  endfunction

  function automatic logic [2:0] count_ge(
    input fwlt_pkg::fwlt_flux_type f,
    input logic [fwlt_pkg::FLUX_W-1:0] v
  );
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < fwlt_pkg::NUM_CH; i++) begin
      n = n + {2'h0, (f.ch[i] >= v)};
    end
    count_ge = n;
  endfunction

  // Register state
  fwlt_pkg::fwlt_mode_type mode_q, mode_d;
  logic [fwlt_pkg::FLUX_W-1:0] enable_sp_q, enable_sp_d;
  logic [fwlt_pkg::FLUX_W-1:0] bypass_sp_q, bypass_sp_d;
  logic [31:0] rdata_q, rdata_d;

  // Trip state
  fwlt_pkg::fwlt_cmp_type cmp_q, cmp_d;
  logic trip_q, trip_d;
  logic alert_q, alert_d;
  logic [fwlt_pkg::FLUX_W-1:0] second_max_q, second_max_d;

  logic [fwlt_pkg::FLUX_W-1:0] sel_power;
  logic [fwlt_pkg::FLUX_W-1:0] own_flux;
  logic [fwlt_pkg::FLUX_W-1:0] sm_now;
  logic own_a_open;
  logic own_b_open;
  logic vote_a;
  logic vote_b;
  logic turbines_tripped;
  logic setup_phase;
  logic wr_en;
  logic addr_ok;

  // Flux values are taken as they come, with no clamp to the expected span
  assign own_flux = flux_in.ch[channel_index];
  assign sm_now = second_max(flux_in);
  assign own_a_open = ~contacts_in.pump_a_pressure_contact[channel_index];
  assign own_b_open = ~contacts_in.pump_b_pressure_contact[channel_index];
  assign vote_a = vote_two_of_four(contacts_in.pump_a_pressure_contact);
  assign vote_b = vote_two_of_four(contacts_in.pump_b_pressure_contact);

  always_comb begin
    if (mode_q == fwlt_pkg::FWLT_PROPOSED) begin
      sel_power = sm_now;
      turbines_tripped = vote_a && vote_b;
    end else begin
      sel_power = own_flux;
      turbines_tripped = own_a_open && own_b_open;
    end
  end

  // Hysteresis comparator; shutdown_bypass has no say here
  always_comb begin
    cmp_d = cmp_q;
    case (cmp_q)
      fwlt_pkg::FWLT_CMP_BYPASSED: begin
        if (sel_power >= enable_sp_q) begin
          cmp_d = fwlt_pkg::FWLT_CMP_ENABLED;
        end
      end
      fwlt_pkg::FWLT_CMP_ENABLED: begin
        if (sel_power < enable_sp_q && sel_power <= bypass_sp_q) begin
          cmp_d = fwlt_pkg::FWLT_CMP_BYPASSED;
        end
      end
      default: cmp_d = fwlt_pkg::FWLT_CMP_BYPASSED;
    endcase
    trip_d = turbines_tripped && (cmp_d == fwlt_pkg::FWLT_CMP_ENABLED);
    alert_d = vote_a || vote_b;
    second_max_d = sm_now;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q <= fwlt_pkg::FWLT_CMP_BYPASSED;
      trip_q <= 1'b0;
      alert_q <= 1'b0;
      second_max_q <= '0;
    end else if (ce) begin
      cmp_q <= cmp_d;
      trip_q <= trip_d;
      alert_q <= alert_d;
      second_max_q <= second_max_d;
    end
  end

  always_comb begin
    trip_out.channel_trip = trip_q;
    trip_out.pressure_alert = alert_q;
    trip_out.trip_bypassed = (cmp_q == fwlt_pkg::FWLT_CMP_BYPASSED);
    trip_out.power_enabled = (cmp_q == fwlt_pkg::FWLT_CMP_ENABLED);
  end

  // APB slave: ready follows ce so a frozen block stretches the access phase
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite && ce;
  assign pready = ce;

  always_comb begin
    if (paddr == fwlt_pkg::ADDR_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == fwlt_pkg::ADDR_ENABLE_SP) begin
      addr_ok = 1'b1;
    end else if (paddr == fwlt_pkg::ADDR_BYPASS_SP) begin
      addr_ok = 1'b1;
    end else if (paddr == fwlt_pkg::ADDR_STATUS) begin
      addr_ok = 1'b1;
    end else if (paddr == fwlt_pkg::ADDR_SECOND_MAX) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel && penable && !addr_ok;
  assign prdata = rdata_q;

  always_comb begin
    mode_d = mode_q;
    enable_sp_d = enable_sp_q;
    bypass_sp_d = bypass_sp_q;
    rdata_d = rdata_q;
    if (wr_en) begin
      if (paddr == fwlt_pkg::ADDR_CTRL) begin
        mode_d = fwlt_pkg::fwlt_mode_type'(pwdata[fwlt_pkg::CTRL_MODE_BIT]);
      end else if (paddr == fwlt_pkg::ADDR_ENABLE_SP) begin
        enable_sp_d = pwdata[fwlt_pkg::FLUX_W-1:0];
      end else if (paddr == fwlt_pkg::ADDR_BYPASS_SP) begin
        bypass_sp_d = pwdata[fwlt_pkg::FLUX_W-1:0];
      end
    end
    if (setup_phase) begin
      rdata_d = 32'h0000_0000;
      if (paddr == fwlt_pkg::ADDR_CTRL) begin
        rdata_d[fwlt_pkg::CTRL_MODE_BIT] = mode_q;
      end else if (paddr == fwlt_pkg::ADDR_ENABLE_SP) begin
        rdata_d[fwlt_pkg::FLUX_W-1:0] = enable_sp_q;
      end else if (paddr == fwlt_pkg::ADDR_BYPASS_SP) begin
        rdata_d[fwlt_pkg::FLUX_W-1:0] = bypass_sp_q;
      end else if (paddr == fwlt_pkg::ADDR_STATUS) begin
        rdata_d[fwlt_pkg::ST_TRIP_BIT] = trip_q;
        rdata_d[fwlt_pkg::ST_ENABLED_BIT] = (cmp_q == fwlt_pkg::FWLT_CMP_ENABLED);
        rdata_d[fwlt_pkg::ST_ALERT_BIT] = alert_q;
        rdata_d[fwlt_pkg::ST_BYPASS_BIT] = (cmp_q == fwlt_pkg::FWLT_CMP_BYPASSED);
        rdata_d[fwlt_pkg::ST_SHUTDOWN_BIT] = shutdown_bypass;
      end else if (paddr == fwlt_pkg::ADDR_SECOND_MAX) begin
        rdata_d[fwlt_pkg::FLUX_W-1:0] = second_max_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= fwlt_pkg::FWLT_LEGACY;
      enable_sp_q <= fwlt_pkg::ENABLE_SP_RST;
      bypass_sp_q <= fwlt_pkg::BYPASS_SP_RST;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      mode_q <= mode_d;
      enable_sp_q <= enable_sp_d;
      bypass_sp_q <= bypass_sp_d;
      rdata_q <= rdata_d;
    end
  end

  a_enable_on_rise: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && sel_power >= enable_sp_q |=> trip_out.power_enabled
  ) else $error("Comparator not enabled at or above enable setpoint");

  a_bypass_on_fall: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && sel_power <= bypass_sp_q && sel_power < enable_sp_q |=> trip_out.trip_bypassed
  ) else $error("Comparator not bypassed at or below bypass setpoint");

  a_hold_enabled: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && trip_out.power_enabled && sel_power > bypass_sp_q |=> trip_out.power_enabled
  ) else $error("Enabled state dropped above bypass setpoint");

  a_no_rise_trip: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && trip_out.trip_bypassed && sel_power < enable_sp_q |=> !trip_q ##0 trip_out.trip_bypassed
  ) else $error("Bypass setpoint acted on rising power");

  a_legacy_trip: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && mode_q == fwlt_pkg::FWLT_LEGACY && own_a_open && own_b_open
      && own_flux >= enable_sp_q |=> trip_q
  ) else $error("Legacy trip missing");

  a_closed_no_trip: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && mode_q == fwlt_pkg::FWLT_LEGACY
      && contacts_in.pump_a_pressure_contact[channel_index] |=> !trip_q
  ) else $error("Closed contact produced a trip");

  a_second_max_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce |=> count_ge($past(flux_in), second_max_q) >= 3'h2
      && (second_max_q == 16'hffff
      || count_ge($past(flux_in), second_max_q + 16'h0001) <= 3'h1)
  ) else $error("Second maximum selection wrong");

  a_vote_no_trip: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && mode_q == fwlt_pkg::FWLT_PROPOSED && !(vote_a && vote_b) |=> !trip_q
  ) else $error("Proposed trip without both votes");

  a_proposed_bypass: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && mode_q == fwlt_pkg::FWLT_PROPOSED && sm_now <= bypass_sp_q
      && sm_now < enable_sp_q |=> !trip_q && trip_out.trip_bypassed
  ) else $error("Proposed bypass not applied");

  a_setpoint_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == fwlt_pkg::ADDR_ENABLE_SP |=> enable_sp_q == $past(pwdata[15:0])
  ) else $error("Enable setpoint write lost");

  a_bypass_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == fwlt_pkg::ADDR_BYPASS_SP |=> bypass_sp_q == $past(pwdata[15:0])
  ) else $error("Bypass setpoint write lost");

  a_mode_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == fwlt_pkg::ADDR_CTRL |=> mode_q == $past(pwdata[0])
  ) else $error("Mode write lost");

  a_proposed_trip: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && mode_q == fwlt_pkg::FWLT_PROPOSED
      && $countones(contacts_in.pump_a_pressure_contact) <= 2
      && $countones(contacts_in.pump_b_pressure_contact) <= 2 && sm_now >= enable_sp_q |=> trip_q
  ) else $error("Proposed trip missing");

  a_shutdown_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && shutdown_bypass && turbines_tripped && sel_power >= enable_sp_q |=> trip_q
  ) else $error("Shutdown bypass inhibited the trip");

  a_alert_unblocked: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && (vote_a || vote_b) |=> alert_q
  ) else $error("Alert missing on two of four open");

  a_alert_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && $countones(contacts_in.pump_a_pressure_contact) >= 3
      && $countones(contacts_in.pump_b_pressure_contact) >= 3 |=> !alert_q
  ) else $error("Alert raised with fewer than two open");

  a_freeze_state: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(cmp_q) && $stable(trip_q) && $stable(enable_sp_q)
  ) else $error("State changed while clock enable low");

  c_proposed_trip: cover property (
    @(posedge pclk) disable iff (!presetn)
    mode_q == fwlt_pkg::FWLT_PROPOSED && trip_q
  );

  c_legacy_trip: cover property (
    @(posedge pclk) disable iff (!presetn)
    mode_q == fwlt_pkg::FWLT_LEGACY && trip_q
  );

  c_enable_then_bypass: cover property (
    @(posedge pclk) disable iff (!presetn)
    trip_out.power_enabled ##[1:50] trip_out.trip_bypassed
  );

  c_shutdown_trip: cover property (
    @(posedge pclk) disable iff (!presetn)
    shutdown_bypass && trip_q
  );

  c_alert_while_bypassed: cover property (
    @(posedge pclk) disable iff (!presetn)
    alert_q && trip_out.trip_bypassed
  );

endmodule
`default_nettype wire

// [tb/fwlt_plant_model.sv]
// Purpose: Field pressure switches and peer channel flux feeding one trip channel.
// Assumes: The bench calls drive just after a rising edge of pclk.
// Notes: Contacts hold their last state; a closed contact reads 1.
`timescale 1ns/1ns
`default_nettype none
module fwlt_plant_model (
  input wire logic pclk,
  output fwlt_pkg::fwlt_flux_type flux_in,
  output fwlt_pkg::fwlt_contacts_type contacts_in
);
  initial begin
    flux_in = '0;
    contacts_in = '1;
  end
  // Open contact drives 0, the tripped state
  task automatic drive(input logic [3:0] a_open, input logic [3:0] b_open,
    input fwlt_pkg::fwlt_flux_type f);
    contacts_in.pump_a_pressure_contact <= ~a_open;
    contacts_in.pump_b_pressure_contact <= ~b_open;
    // Every peer reads this same shared flux picture, feeding each channel's own second-highest selection
    flux_in <= f;
  endtask
endmodule
`default_nettype wire

// [tb/fwlt_trip_channel_bench.sv]
// Purpose: Self-checking bench for the feedwater-loss trip channel.
// Assumes: ce high except in one freeze check; zero-wait APB.
// Notes: A reference model of vote, second max and hysteresis runs beside it.
`timescale 1ns/1ns
`default_nettype none
module fwlt_trip_channel_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] channel_index = 2'h0;
  logic shutdown_bypass = 1'b0;
  fwlt_pkg::fwlt_flux_type flux_in;
  fwlt_pkg::fwlt_contacts_type contacts_in;
  fwlt_pkg::fwlt_out_type trip_out;
  int failures = 0;
  int n_tests = 0;
  int ensp = 175;
  int bysp = 50;
  int smax_m = 0;
  logic mode_m = 1'b0;
  logic en_m = 1'b0;
  logic [3:0] exp_out = 4'h2;
  fwlt_pkg::fwlt_flux_type last_f;

  always #4 pclk = ~pclk;

  fwlt_trip_channel u_fwlt_trip_channel (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_index(channel_index),
    .shutdown_bypass(shutdown_bypass), .flux_in(flux_in), .contacts_in(contacts_in),
    .trip_out(trip_out));
  fwlt_plant_model u_fwlt_plant_model (.pclk(pclk), .flux_in(flux_in),
    .contacts_in(contacts_in));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Hysteresis comparator; enable wins where the setpoints overlap
  function automatic logic hyst(input logic en, input int s, input int e, input int b);
    if (s >= e) return 1'b1;
    if (s <= b) return 1'b0;
    return en;
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, exp, "register read");
    check({31'h0, err}, {31'h0, exp_err}, "slave error");
  endtask

  // Apply one plant state, advance the model and compare one cycle later
  task automatic step(input logic [3:0] ao, input logic [3:0] bo,
    input fwlt_pkg::fwlt_flux_type f, input logic [1:0] idx);
    int sel, m1, m2, v;
    logic tr;
    @(posedge pclk);
    channel_index <= idx;
    u_fwlt_plant_model.drive(ao, bo, f);
    last_f = f;
    m1 = 0;
    m2 = 0;
    for (int i = 0; i < 4; i++) begin
      v = int'(f.ch[i]);
      if (v >= m1) begin
        m2 = m1;
        m1 = v;
      end else if (v > m2) begin
        m2 = v;
      end
    end
    smax_m = m2;
    sel = mode_m ? m2 : int'(f.ch[idx]);
    en_m = hyst(en_m, sel, ensp, bysp);
    if (mode_m) tr = $countones(ao) >= 2 && $countones(bo) >= 2;
    else tr = ao[idx] && bo[idx];
    exp_out = {en_m && tr, $countones(ao) >= 2 || $countones(bo) >= 2, !en_m, en_m};
    @(posedge pclk);
    #1;
    check(32'(trip_out), {28'h0, exp_out}, "trip outputs");
  endtask

  initial begin
    #200000;
    failures++;
    finish_test();
  end

  initial begin
    int lv[8] = '{100, 175, 100, 51, 50, 100, 176, 12500};
    fwlt_pkg::fwlt_flux_type f;
    int oe, ob, s;
    void'($urandom(32'hfbe5));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check(32'(trip_out), 32'h2, "reset outputs");
    rchk(fwlt_pkg::ADDR_CTRL, 32'h0, 1'b0);
    rchk(fwlt_pkg::ADDR_ENABLE_SP, 32'h00af, 1'b0);
    rchk(fwlt_pkg::ADDR_BYPASS_SP, 32'h0032, 1'b0);
    rchk(12'h014, 32'h0, 1'b1);
    wreg(fwlt_pkg::ADDR_STATUS, 32'hffffffff);
    rchk(fwlt_pkg::ADDR_STATUS, 32'h8, 1'b0);
    // Legacy sweep: peers sit high, only the own flux and own contacts count
    for (int k = 0; k < 16; k++) begin
      f.ch = {16'h30d4, 16'h30d4, 16'h30d4, 16'h30d4};
      f.ch[2] = 16'(lv[k % 8]);
      step(k[0] ? 4'b0100 : 4'b1011, k[0] ? 4'b0100 : 4'b1011, f, 2'h2);
    end
    // Random proposed and legacy traffic with setpoints moved on the fly
    for (int k = 0; k < 300; k++) begin
      if (k % 16 == 0) begin
        oe = ensp;
        ob = bysp;
        mode_m = (k == 0) ? 1'b1 : 1'(($urandom() & 32'h1));
        ensp = 35 * $urandom_range(1, 6);
        bysp = 35 * $urandom_range(0, 5);
        wreg(fwlt_pkg::ADDR_CTRL, {31'h0, mode_m});
        wreg(fwlt_pkg::ADDR_ENABLE_SP, 32'(ensp));
        wreg(fwlt_pkg::ADDR_BYPASS_SP, 32'(bysp));
        // The held plant state meets each new setting in turn as the writes land
        s = mode_m ? smax_m : int'(last_f.ch[channel_index]);
        en_m = hyst(hyst(hyst(en_m, s, oe, ob), s, ensp, ob), s, ensp, bysp);
        rchk(fwlt_pkg::ADDR_ENABLE_SP, 32'(ensp), 1'b0);
        rchk(fwlt_pkg::ADDR_BYPASS_SP, 32'(bysp), 1'b0);
        rchk(fwlt_pkg::ADDR_CTRL, {31'h0, mode_m}, 1'b0);
        @(posedge pclk);
        shutdown_bypass <= 1'(($urandom() & 32'h1));
      end
      for (int i = 0; i < 4; i++) f.ch[i] = 16'(35 * $urandom_range(0, 6));
      step(4'($urandom()), 4'($urandom()), f, 2'($urandom()));
      if (k % 16 == 15) begin
        rchk(fwlt_pkg::ADDR_SECOND_MAX, 32'(smax_m), 1'b0);
        rchk(fwlt_pkg::ADDR_STATUS, {27'h0, shutdown_bypass, exp_out[1], exp_out[2],
          exp_out[0], exp_out[3]}, 1'b0);
      end
    end
    // Clock enable low freezes the outputs while contacts open
    @(posedge pclk);
    ce <= 1'b0;
    u_fwlt_plant_model.drive(4'hf, 4'hf, last_f);
    repeat (3) @(posedge pclk);
    #1;
    check(32'(trip_out), {28'h0, exp_out}, "frozen outputs");
    check(32'(pready), 32'h0, "ready while frozen");
    @(posedge pclk);
    ce <= 1'b1;
    step(4'hf, 4'hf, last_f, channel_index);
    finish_test();
  end
endmodule
`default_nettype wire
